// file: inc/adcbs_pkg.sv
/*
  Shared constants and types for the converter's output-select and sequencing logic.
  Assumes a single 25 MHz system clock; all counts below are in cycles of it.
*/
package adcbs_pkg;
  localparam int RES_W = 12;
  localparam int CNT_W = 9;
  // Clock rate and documented conversion times
  localparam int CLK_MHZ = 25;
  localparam int T_CONV12_US = 12;
  localparam int T_CONV8_US = 8;
  localparam logic [CNT_W-1:0] CONV12_CYC = CNT_W'(T_CONV12_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CONV8_CYC = CNT_W'(T_CONV8_US * CLK_MHZ);
  // One approximation step per slot; 13 slots fit in 300 cycles, 9 in 200
  localparam logic [CNT_W-1:0] SLOT_CYC = 9'h016;
  // Bit weights of the approximation register
  localparam logic [RES_W-1:0] MSB_MASK = 12'h800;
  localparam logic [RES_W-1:0] LSB12_MASK = 12'h001;
  localparam logic [RES_W-1:0] LSB8_MASK = 12'h010;
  // Low nibble of a full read after a short conversion
  localparam logic [3:0] SHORT_TAIL = 4'h8;
  // Reset values
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam int SYNC_W = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h00;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'b00,
    SAR_BITS = 2'b01,
    SAR_CORR = 2'b10,
    SAR_DONE = 2'b11
  } adcbs_sar_st_t;
endpackage : adcbs_pkg

// file: inc/adcbs_sar_if.sv
/*
  Link between the sequencing control and the approximation engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface adcbs_sar_if;
  logic start;
  logic step;
  logic short_mode;
  logic comp;
  logic [11:0] dac_code;
  logic [11:0] result;
  logic done;
  modport ctl (output start, output step, output short_mode, output comp,
    input dac_code, input result, input done);
  modport sar (input start, input step, input short_mode, input comp,
    output dac_code, output result, output done);
endinterface : adcbs_sar_if

// file: hw/adcbs_sar.sv
/*
  Successive-approximation engine with one redundant correction step.
  Assumes start only while idle and one step pulse per settled comparator decision.
*/
`timescale 1ns/10ps
module adcbs_sar (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control link
  adcbs_sar_if.sar sif
);
  import adcbs_pkg::*;

  adcbs_sar_st_t st_ff, nxt_st;
  logic [RES_W-1:0] code_ff, nxt_code, mask_ff, nxt_mask, dac_ff, nxt_dac;
  logic [RES_W-1:0] lsb, code_k;
  logic [RES_W:0] sum;

  always_comb begin
    lsb = sif.short_mode ? LSB8_MASK : LSB12_MASK;
    code_k = sif.comp ? (code_ff | mask_ff) : code_ff;
    sum = {1'b0, code_k} + {1'b0, lsb};
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_mask = mask_ff;
    nxt_dac = dac_ff;
    case (st_ff)
      SAR_IDLE, SAR_DONE: begin
        if (sif.start) begin
          nxt_st = SAR_BITS;
          nxt_code = RESULT_RST;
          nxt_mask = MSB_MASK;
          nxt_dac = MSB_MASK;
        end
      end
      SAR_BITS: begin
        if (sif.step) begin
          nxt_code = code_k;
          // A late length change may leave the mask below the new LSB
          if (mask_ff <= lsb) begin
            nxt_st = SAR_CORR;
            nxt_dac = sum[RES_W] ? code_k : sum[RES_W-1:0];
          end else begin
            nxt_mask = mask_ff >> 1;
            nxt_dac = code_k | (mask_ff >> 1);
          end
        end
      end
      SAR_CORR: begin
        if (sif.step) begin
          // Redundant compare one LSB up repairs a low decision made too early
          if (sif.comp && (dac_ff != code_ff)) begin
            nxt_code = dac_ff;
          end
          nxt_st = SAR_DONE;
        end
      end
      default: nxt_st = SAR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= SAR_IDLE;
      code_ff <= RESULT_RST;
      mask_ff <= RESULT_RST;
      dac_ff <= RESULT_RST;
    end else begin
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      mask_ff <= nxt_mask;
      dac_ff <= nxt_dac;
    end
  end

  assign sif.dac_code = dac_ff;
  assign sif.result = code_ff;
  assign sif.done = (st_ff == SAR_DONE);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_corr_one_lsb: assert property (
    (st_ff == SAR_CORR) && sif.step |=> (code_ff == $past(code_ff))
      || (code_ff == $past(code_ff) + $past(lsb)))
    else $error("correction moved the code by more than one step");
  chk_bit_keep: assert property (
    (st_ff == SAR_BITS) && sif.step && sif.comp |=> ((code_ff & $past(mask_ff)) != 12'h000))
    else $error("accepted trial bit not kept");
endmodule : adcbs_sar

// file: hw/adcbs_top.sv
/*
  Read-out and sequencing logic of a 12-bit successive-approximation converter:
  conversion start, busy timing, word/byte output selection with break-before-make.
  Assumes all control pins and the comparator are asynchronous to sys_clk; the pads
  combine result_lines_o with result_lines_oe and strap the byte groups outside.
*/
`timescale 1ns/10ps
module adcbs_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus control pins
  input wire logic chip_en,
  input wire logic chip_sel_n,
  input wire logic read_conv,
  input wire logic word_wide,
  input wire logic byte_select,
  // Analog front end
  input wire logic comp_above,
  output logic [adcbs_pkg::RES_W-1:0] dac_code,
  // Result bus and status
  output logic [adcbs_pkg::RES_W-1:0] result_lines_o,
  output logic [adcbs_pkg::RES_W-1:0] result_lines_oe,
  output logic conversion_busy
);
  import adcbs_pkg::*;

  adcbs_sar_if sif ();

  logic [SYNC_W-1:0] sync_a_ff, sync_b_ff;
  logic comp_s, ce_s, csn_s, rc_s, word_s, a0_s;
  logic start_cond, cond_ff, start_evt;

  // Pins pass two flops; only the second stage is read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_a_ff <= SYNC_RST;
      sync_b_ff <= SYNC_RST;
    end else begin
      sync_a_ff <= {comp_above, chip_en, chip_sel_n, read_conv, word_wide, byte_select};
      sync_b_ff <= sync_a_ff;
    end
  end
  assign {comp_s, ce_s, csn_s, rc_s, word_s, a0_s} = sync_b_ff;

  // Whichever of the three start inputs arrives last fires the start
  assign start_cond = ce_s & ~csn_s & ~rc_s;
  assign start_evt = start_cond & ~cond_ff;

  // Conversion sequencing
  logic busy_ff, nxt_busy, short_ff, nxt_short;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, slot_ff, nxt_slot, conv_len;
  logic [RES_W-1:0] result_ff, nxt_result;

  always_comb begin
    conv_len = short_ff ? CONV8_CYC : CONV12_CYC;
    nxt_busy = busy_ff;
    nxt_short = short_ff;
    nxt_cnt = cnt_ff;
    nxt_slot = slot_ff;
    nxt_result = result_ff;
    if (start_evt) begin
      nxt_short = a0_s;
    end
    if (!busy_ff) begin
      if (start_evt) begin
        nxt_busy = 1'b1;
        nxt_cnt = CNT_RST;
        nxt_slot = CNT_RST;
      end
    end else begin
      // A repeated start while busy leaves the counters alone
      nxt_cnt = cnt_ff + 9'h001;
      nxt_slot = (slot_ff == SLOT_CYC - 9'h001) ? CNT_RST : slot_ff + 9'h001;
      if (cnt_ff == conv_len - 9'h001) begin
        nxt_busy = 1'b0;
        nxt_result = short_ff ? {sif.result[11:4], SHORT_TAIL} : sif.result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cond_ff <= 1'b0;
      busy_ff <= 1'b0;
      short_ff <= 1'b0;
      cnt_ff <= CNT_RST;
      slot_ff <= CNT_RST;
      result_ff <= RESULT_RST;
    end else begin
      cond_ff <= start_cond;
      busy_ff <= nxt_busy;
      short_ff <= nxt_short;
      cnt_ff <= nxt_cnt;
      slot_ff <= nxt_slot;
      result_ff <= nxt_result;
    end
  end

  assign sif.start = start_evt & ~busy_ff;
  assign sif.step = busy_ff & (slot_ff == SLOT_CYC - 9'h001);
  assign sif.short_mode = short_ff;
  assign sif.comp = comp_s;

  adcbs_sar u_sar (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sif(sif.sar)
  );

  // Output enables and data
  logic rd_ok, want_hi, want_lo;
  logic oe_hi_ff, nxt_oe_hi, oe_mid_ff, nxt_oe_mid, oe_lo_ff, nxt_oe_lo;
  logic [RES_W-1:0] data_ff, nxt_data;

  always_comb begin
    rd_ok = rc_s & ~busy_ff & ce_s & ~csn_s;
    want_hi = rd_ok & (word_s | ~a0_s);
    want_lo = rd_ok & (word_s | a0_s);
    // In byte mode the upper and lower nibbles share wires, so never overlap them
    nxt_oe_hi = want_hi & (word_s | ~oe_lo_ff);
    nxt_oe_lo = want_lo & (word_s | ~oe_hi_ff);
    nxt_oe_mid = rd_ok;
    nxt_data = (word_s | ~a0_s) ? result_ff : {8'h00, result_ff[3:0]};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oe_hi_ff <= 1'b0;
      oe_mid_ff <= 1'b0;
      oe_lo_ff <= 1'b0;
      data_ff <= RESULT_RST;
    end else begin
      oe_hi_ff <= nxt_oe_hi;
      oe_mid_ff <= nxt_oe_mid;
      oe_lo_ff <= nxt_oe_lo;
      data_ff <= nxt_data;
    end
  end

  assign result_lines_o = data_ff;
  assign result_lines_oe = {{4{oe_hi_ff}}, {4{oe_mid_ff}}, {4{oe_lo_ff}}};
  assign conversion_busy = busy_ff;
  assign dac_code = sif.dac_code;

  // Helper: length of the busy pulse just ended
  logic [CNT_W-1:0] dur_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dur_ff <= CNT_RST;
    end else begin
      dur_ff <= busy_ff ? dur_ff + 9'h001 : CNT_RST;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_busy_len_12: assert property (
    $fell(busy_ff) && !$past(short_ff) |-> $past(dur_ff) == 9'h12B)
    else $error("12-bit busy not 300 cycles");
  chk_busy_len_8: assert property (
    $fell(busy_ff) && $past(short_ff) |-> $past(dur_ff) == 9'h0C7)
    else $error("8-bit busy not 200 cycles");
  chk_start_capture: assert property (
    start_evt |=> short_ff == $past(a0_s))
    else $error("byte select not captured at start");
  chk_restart_ignored: assert property (
    busy_ff && start_evt && (cnt_ff != conv_len - 9'h001)
      |=> busy_ff && (cnt_ff == $past(cnt_ff) + 9'h001))
    else $error("start during busy disturbed the conversion");
  chk_float_idle: assert property (
    !$past(rd_ok) |-> result_lines_oe == 12'h000)
    else $error("lines driven without a read");
  chk_word_all_on: assert property (
    rd_ok && word_s ##1 rd_ok && word_s |=> result_lines_oe == 12'hFFF)
    else $error("wide read not all lines");
  chk_no_overlap: assert property (
    oe_hi_ff && oe_lo_ff |-> $past(word_s))
    else $error("byte groups enabled together");
  chk_byte1_only: assert property (
    $past(rd_ok && !word_s && !a0_s) |-> result_lines_oe[3:0] == 4'h0)
    else $error("low nibble driven for upper byte");
  chk_byte2_zero: assert property (
    oe_lo_ff && !$past(word_s) |-> result_lines_o[11:4] == 8'h00)
    else $error("second byte not zero padded");
  chk_short_tail: assert property (
    $fell(busy_ff) && $past(short_ff) |-> result_ff[3:0] == SHORT_TAIL)
    else $error("short result tail wrong");
  chk_busy_only_conv: assert property (
    $rose(busy_ff) |-> $past(start_evt) && cnt_ff == CNT_RST)
    else $error("busy rose without a start");

  cov_conv12: cover property ($fell(busy_ff) && !$past(short_ff));
  cov_conv8: cover property ($fell(busy_ff) && $past(short_ff));
  cov_byte_swap: cover property (oe_hi_ff && !word_s ##[1:8] oe_lo_ff);
  cov_restart: cover property (busy_ff && start_evt);
endmodule : adcbs_top

// file: verif/adcbs_host.sv
/*
  Host model: drives the control pins and reads the result bus.
  Assumes the converter samples pins on the rising clock edge.
*/
`timescale 1ns/10ps
module adcbs_host (
  // Clock
  input wire logic sys_clk,
  // Control pins
  output logic chip_en,
  output logic chip_sel_n,
  output logic read_conv,
  output logic word_wide,
  output logic byte_select,
  // Result bus and status
  input wire logic [11:0] res_o,
  input wire logic [11:0] res_oe,
  input wire logic conversion_busy
);
  logic [11:0] flt = 12'h5A5;
  // Undriven lines toggle, so a stale value never passes
  wire [11:0] bus = (res_o & res_oe) | (flt & ~res_oe);

  always @(posedge sys_clk) flt <= ~flt;
  initial {chip_en, chip_sel_n, read_conv, word_wide, byte_select} = 5'h16;

  task automatic pins(input logic en, input logic csn);
    @(negedge sys_clk);
    chip_en = en;
    chip_sel_n = csn;
  endtask : pins

  // Nonzero poke lifts and re-drops the request mid-conversion
  task automatic conv(input logic bsel, input int poke, output logic [11:0] len);
    int n;
    @(negedge sys_clk);
    byte_select = bsel;
    repeat (3) @(negedge sys_clk);
    read_conv = 1'b0;
    n = 0;
    len = 12'h000;
    while (conversion_busy !== 1'b1 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    while (conversion_busy === 1'b1 && len < 12'h190) begin
      if (poke > 0 && len == 12'(poke)) read_conv = 1'b1;
      if (poke > 0 && len == 12'(poke + 4)) read_conv = 1'b0;
      @(negedge sys_clk);
      len++;
    end
    read_conv = 1'b1;
  endtask : conv

  task automatic rd(input logic w, input logic b, output logic [11:0] oe,
    output logic [11:0] val);
    @(negedge sys_clk);
    word_wide = w;
    byte_select = b;
    repeat (5) @(negedge sys_clk);
    oe = res_oe;
    val = bus;
  endtask : rd
endmodule : adcbs_host

// file: verif/adcbs_top_tb.sv
/*
  Self-checking bench: busy timing, word and byte reads, floating.
  Assumes the host model drives pins and an ideal comparator tracks vin.
*/
`timescale 1ns/10ps
module adcbs_top_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic comp_above = 1'b0;
  logic [11:0] vin = 12'h000;
  logic chip_en, chip_sel_n, read_conv, word_wide, byte_select, busy;
  logic [11:0] dac, res_o, res_oe, oe, val, len;
  int err_total = 0;
  int n_checks = 0;

  always #20 sys_clk = ~sys_clk;
  // Input sits mid-code: a trial at or below vin reads as above
  always @(negedge sys_clk) comp_above <= (vin >= dac);

  adcbs_top DUT (.sys_clk(sys_clk), .rstn(rstn), .chip_en(chip_en),
    .chip_sel_n(chip_sel_n), .read_conv(read_conv), .word_wide(word_wide),
    .byte_select(byte_select), .comp_above(comp_above), .dac_code(dac),
    .result_lines_o(res_o), .result_lines_oe(res_oe), .conversion_busy(busy));
  adcbs_host host (.sys_clk(sys_clk), .chip_en(chip_en), .chip_sel_n(chip_sel_n),
    .read_conv(read_conv), .word_wide(word_wide), .byte_select(byte_select),
    .res_o(res_o), .res_oe(res_oe), .conversion_busy(busy));

  task automatic check(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic conv(input logic bsel, input int poke);
    host.conv(bsel, poke, len);
    if (len == 12'h000 || len == 12'h190) begin
      $display("ERROR conv_busy expected a bounded busy pulse seen %h", len);
      err_total++;
      complete_run();
    end
  endtask : conv

  logic busy_q = 1'b0;
  logic [3:0] wide_hist = 4'hF;
  // Wide reads drive both groups on purpose; only judge once byte mode has settled
  always @(posedge sys_clk) wide_hist <= {wide_hist[2:0], word_wide};

  always @(negedge sys_clk) if (rstn) begin
    busy_q <= busy;
    if (wide_hist == 4'h0)
      check("both_bytes", {11'h000, res_oe[11] & res_oe[3]}, 12'h000);
    if (busy) check("oe_busy", res_oe, 12'h000);
    if (busy && !busy_q) check("dac_first", dac, 12'h800);
  end

  task automatic t_full();
    vin = 12'hA5C;
    conv(1'b0, 0);
    check("len12", len, 12'h12C);
    host.rd(1'b1, 1'b0, oe, val);
    check("oe_wide", oe, 12'hFFF);
    check("data", val & oe, 12'hA5C);
    host.rd(1'b1, 1'b1, oe, val);
    check("oe_wide", oe, 12'hFFF);
    host.rd(1'b0, 1'b0, oe, val);
    check("oe_hi", oe, 12'hFF0);
    check("byte1", val & oe, 12'hA50);
    host.rd(1'b0, 1'b1, oe, val);
    check("oe_lo", oe, 12'h0FF);
    check("byte2", val & oe, 12'h00C);
    host.rd(1'b0, 1'b0, oe, val);
    check("oe_hi", oe, 12'hFF0);
    $display("test full done");
  endtask : t_full

  task automatic t_short();
    vin = 12'h3E7;
    conv(1'b1, 0);
    check("len8", len, 12'h0C8);
    host.rd(1'b1, 1'b0, oe, val);
    check("short", val & oe, 12'h3E8);
    host.rd(1'b0, 1'b1, oe, val);
    check("short_lo", val & oe, 12'h008);
    $display("test short done");
  endtask : t_short

  task automatic t_float();
    host.pins(1'b0, 1'b0);
    host.rd(1'b1, 1'b0, oe, val);
    check("oe_no_en", oe, 12'h000);
    host.pins(1'b1, 1'b1);
    host.rd(1'b1, 1'b0, oe, val);
    check("oe_no_sel", oe, 12'h000);
    host.pins(1'b1, 1'b0);
    host.rd(1'b1, 1'b0, oe, val);
    check("oe_back", oe, 12'hFFF);
    $display("test float done");
  endtask : t_float

  task automatic t_restart();
    vin = 12'h001;
    conv(1'b0, 100);
    check("len_again", len, 12'h12C);
    host.rd(1'b1, 1'b0, oe, val);
    check("data_min", val & oe, 12'h001);
    $display("test restart done");
  endtask : t_restart

  initial begin
    repeat (8) @(negedge sys_clk);
    check("oe_rst", res_oe, 12'h000);
    check("busy_rst", {11'h000, busy}, 12'h000);
    rstn = 1'b1;
    t_full();
    t_short();
    t_float();
    t_restart();
    complete_run();
  end
endmodule : adcbs_top_tb
